// >>> spfcad_decode.v
// serial flash instruction decoder with extended address and bank logic
//
// Notes on behaviour
// - 0C fast, 13 normal read: always 4-byte
// - 3C dual-out, 6C quad-out read: 4-byte
// - BC dual I/O, EC quad I/O: 4-byte
// - 12 program, 34 quad program: 4-byte
// - 21 4k erase, DC sector erase: 4-byte
// - extended-address bit cleared at reset
// - extended bit set: legacy commands take four bytes
// - 03 normal, 0B fast read: width follows bit
// - 3B dual-out, 6B quad-out: width follows bit
// - BB dual I/O, EB quad I/O: width follows bit
// - 02 program, 32 quad program: width follows bit
// - 20 4k erase, D8 sector erase: width follows
// - 3-byte mode: bank register is top byte
// - bank register volatile, bank 0 after reset
// - reads stream across banks without delay
// - bank register untouched by streaming reads
// - 90 signature, 9F identity, 5A parameters
// - 05, 07 status reads, 35 config read
// - 01 register write, 06/04 write enable/disable
// - 30 clears fail flags
// - 16 bank read, 17 and B9 bank write
// - 41 pattern read, 43/4A pattern writes
// - 8-bit instruction first, address MSB first
`timescale 1ns/100ps
`default_nettype none
`include "spfcad_defs.vh"

module spfcad_decode #(
   parameter LAT_CYC = 8,
   parameter FIFO_DEPTH = 4
) (
   // clock and reset
   input wire clk_sys,
   input wire arst_n,
   // serial pins
   input wire cs_n,
   input wire sck,
   input wire [3:0] io_in,
   output wire [3:0] io_out,
   output reg [3:0] io_oe,
   // read data from array or register store
   input wire [7:0] rd_data,
   input wire rd_valid,
   output wire rd_ready,
   // decoded command
   output reg [7:0] op_code,
   output reg [3:0] op_class,
   output reg op_strobe,
   output reg op_wide,
   output reg [31:0] op_addr,
   output reg op_addr_strobe,
   output reg [31:0] stream_addr,
   // write data and framing
   output reg [7:0] wr_data,
   output reg wr_strobe,
   output reg frame_end,
   // bank register
   output reg [7:0] bank_address_select,
   output wire wide_address_enable
);
   localparam ST_INST = 3'h0;
   localparam ST_ADDR = 3'h1;
   localparam ST_LAT = 3'h2;
   localparam ST_DIN = 3'h3;
   localparam ST_DOUT = 3'h4;
   localparam ST_IGN = 3'h5;

   function [3:0] cls_of;
      input [7:0] op;
      begin
         case (op)
            `OP_QUICK_READ_WIDE, `OP_NORMAL_READ_WIDE,
            `OP_READ_DUAL_OUT_WIDE, `OP_READ_QUAD_OUT_WIDE,
            `OP_READ_DUAL_IO_WIDE, `OP_READ_QUAD_IO_WIDE,
            `OP_NORMAL_READ, `OP_QUICK_READ,
            `OP_READ_DUAL_OUT, `OP_READ_QUAD_OUT,
            `OP_READ_DUAL_IO, `OP_READ_QUAD_IO: cls_of = `CLS_READ;
            `OP_PAGE_PROGRAM_WIDE, `OP_QUAD_PAGE_PROGRAM_WIDE,
            `OP_PAGE_PROGRAM,
            `OP_QUAD_PAGE_PROGRAM: cls_of = `CLS_PROGRAM;
            `OP_PARAM_4K_WIPE_WIDE, `OP_LARGE_BLOCK_WIPE_WIDE,
            `OP_PARAM_4K_WIPE,
            `OP_LARGE_BLOCK_WIPE: cls_of = `CLS_ERASE;
            `OP_READ_MAKER_SIGNATURE, `OP_READ_IDENTITY,
            `OP_READ_DISCOVERY_PARAMS, `OP_READ_STATUS_ONE,
            `OP_READ_STATUS_TWO, `OP_READ_CONFIG_ONE,
            `OP_LEARN_PATTERN_READ: cls_of = `CLS_REG_READ;
            `OP_WRITE_STATUS_CONFIG, `OP_LEARN_PATTERN_NV_PROGRAM,
            `OP_LEARN_PATTERN_VOL_WRITE: cls_of = `CLS_REG_WRITE;
            `OP_WRITE_ENABLE_CMD, `OP_WRITE_DISABLE_CMD,
            `OP_CLEAR_FAIL_FLAGS: cls_of = `CLS_SIMPLE;
            `OP_BANK_REG_READ: cls_of = `CLS_BANK_READ;
            `OP_BANK_REG_WRITE,
            `OP_BANK_REG_ACCESS_LEGACY: cls_of = `CLS_BANK_WRITE;
            default: cls_of = `CLS_NONE;
         endcase
      end
   endfunction

   function [1:0] akind_of;
      input [7:0] op;
      begin
         case (op)
            `OP_QUICK_READ_WIDE, `OP_NORMAL_READ_WIDE: akind_of = `AK_FIXED4;
            `OP_READ_DUAL_OUT_WIDE,
            `OP_READ_QUAD_OUT_WIDE: akind_of = `AK_FIXED4;
            `OP_READ_DUAL_IO_WIDE,
            `OP_READ_QUAD_IO_WIDE: akind_of = `AK_FIXED4;
            `OP_PAGE_PROGRAM_WIDE,
            `OP_QUAD_PAGE_PROGRAM_WIDE: akind_of = `AK_FIXED4;
            `OP_PARAM_4K_WIPE_WIDE,
            `OP_LARGE_BLOCK_WIPE_WIDE: akind_of = `AK_FIXED4;
            `OP_NORMAL_READ, `OP_QUICK_READ: akind_of = `AK_LEGACY;
            `OP_READ_DUAL_OUT, `OP_READ_QUAD_OUT: akind_of = `AK_LEGACY;
            `OP_READ_DUAL_IO, `OP_READ_QUAD_IO: akind_of = `AK_LEGACY;
            `OP_PAGE_PROGRAM,
            `OP_QUAD_PAGE_PROGRAM: akind_of = `AK_LEGACY;
            `OP_PARAM_4K_WIPE,
            `OP_LARGE_BLOCK_WIPE: akind_of = `AK_LEGACY;
            default: akind_of = `AK_NONE;
         endcase
      end
   endfunction

   // lines per edge in the address phase
   function [2:0] abw_of;
      input [7:0] op;
      begin
         case (op)
            `OP_READ_DUAL_IO, `OP_READ_DUAL_IO_WIDE: abw_of = 3'h2;
            `OP_READ_QUAD_IO, `OP_READ_QUAD_IO_WIDE: abw_of = 3'h4;
            default: abw_of = 3'h1;
         endcase
      end
   endfunction

   // lines per edge in the data phase
   function [2:0] dbw_of;
      input [7:0] op;
      begin
         case (op)
            `OP_READ_DUAL_OUT, `OP_READ_DUAL_OUT_WIDE,
            `OP_READ_DUAL_IO, `OP_READ_DUAL_IO_WIDE: dbw_of = 3'h2;
            `OP_READ_QUAD_OUT, `OP_READ_QUAD_OUT_WIDE,
            `OP_READ_QUAD_IO, `OP_READ_QUAD_IO_WIDE,
            `OP_QUAD_PAGE_PROGRAM,
            `OP_QUAD_PAGE_PROGRAM_WIDE: dbw_of = 3'h4;
            default: dbw_of = 3'h1;
         endcase
      end
   endfunction

   // reads that insert latency cycles before data
   function has_lat;
      input [7:0] op;
      begin
         case (op)
            `OP_NORMAL_READ, `OP_NORMAL_READ_WIDE: has_lat = 1'b0;
            `OP_READ_DISCOVERY_PARAMS: has_lat = 1'b1;
            default: has_lat = (cls_of(op) == `CLS_READ);
         endcase
      end
   endfunction

   // bits captured on one rising edge, io0 lowest
   function [3:0] take;
      input [2:0] bw;
      input [3:0] io;
      begin
         case (bw)
            3'h2: take = {2'h0, io[1:0]};
            3'h4: take = io;
            default: take = {3'h0, io[0]};
         endcase
      end
   endfunction

   // pin synchronisers: cs_n, sck, io[3:0]
   reg [5:0] sync1;
   reg [5:0] sync2;
   reg [5:0] sync3;
   reg [5:0] filt;
   reg sck_d;
   reg cs_d;
   wire f_cs_n = filt[5];
   wire f_sck = filt[4];
   wire [3:0] f_io = filt[3:0];
   wire sck_rise = f_sck & ~sck_d & ~f_cs_n;
   wire sck_fall = ~f_sck & sck_d & ~f_cs_n;

   genvar g;
   generate
      for (g = 0; g < 6; g = g + 1) begin : g_filt
         always @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n) begin
               filt[g] <= (g == 5) ? 1'b1 : 1'b0;
            end else if (sync2[g] == sync3[g]) begin
               filt[g] <= sync3[g];
            end
         end
      end
   endgenerate

   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         sync1 <= 6'h20;
         sync2 <= 6'h20;
         sync3 <= 6'h20;
         sck_d <= 1'b0;
         cs_d <= 1'b1;
      end else begin
         sync1 <= {cs_n, sck, io_in};
         sync2 <= sync1;
         sync3 <= sync2;
         sck_d <= f_sck;
         cs_d <= f_cs_n;
      end
   end

   // read data buffer; stalls the array source when full
   wire [7:0] fifo_data;
   wire fifo_valid;
   reg fifo_pop;

   spfcad_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .in_data(rd_data),
      .in_valid(rd_valid),
      .in_ready(rd_ready),
      .out_data(fifo_data),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop)
   );

   reg [2:0] state;
   reg [5:0] bitcnt;
   reg [5:0] addr_bits;
   reg [31:0] ash;
   reg [7:0] dsh;
   reg [7:0] out_sh;
   reg [3:0] out_left;
   reg [2:0] abw;
   reg [2:0] dbw;
   reg [7:0] lat_cnt;
   reg [31:0] next_ash;
   reg [7:0] next_dsh;
   reg [7:0] next_byte;

   assign wide_address_enable = bank_address_select[`BANK_EXT_BIT];
   assign io_out = (dbw == 3'h4) ? out_sh[7:4] :
                   (dbw == 3'h2) ? {2'h0, out_sh[7:6]} :
                   {2'h0, out_sh[7], 1'b0};

   always @* begin
      next_ash = (ash << abw) | {28'h0, take(abw, f_io)};
      next_dsh = (dsh << dbw) | {4'h0, take(dbw, f_io)};
      next_byte = (op_class == `CLS_BANK_READ) ? bank_address_select :
                  (fifo_valid ? fifo_data : `IDLE_BYTE);
      fifo_pop = (state == ST_DOUT) & sck_fall & (out_left == 4'h0) &
                 (op_class != `CLS_BANK_READ) & fifo_valid;
   end

   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         state <= ST_INST;
         bitcnt <= 6'h00;
         addr_bits <= `BITS_ADDR3;
         ash <= 32'h0;
         dsh <= 8'h00;
         out_sh <= 8'h00;
         out_left <= 4'h0;
         abw <= 3'h1;
         dbw <= 3'h1;
         lat_cnt <= 8'h00;
         io_oe <= 4'h0;
         op_code <= 8'h00;
         op_class <= `CLS_NONE;
         op_strobe <= 1'b0;
         op_wide <= 1'b0;
         op_addr <= 32'h0;
         op_addr_strobe <= 1'b0;
         stream_addr <= 32'h0;
         wr_data <= 8'h00;
         wr_strobe <= 1'b0;
         frame_end <= 1'b0;
         bank_address_select <= `BANK_RESET;
      end else begin
         op_strobe <= 1'b0;
         op_addr_strobe <= 1'b0;
         wr_strobe <= 1'b0;
         frame_end <= f_cs_n & ~cs_d;
         if (f_cs_n) begin
            // deselect ends any command and frees the lines
            state <= ST_INST;
            bitcnt <= 6'h00;
            out_left <= 4'h0;
            io_oe <= 4'h0;
            dbw <= 3'h1;
         end else if (sck_rise) begin
            case (state)
               ST_INST: begin
                  dsh <= {dsh[6:0], f_io[0]};
                  bitcnt <= bitcnt + 6'h01;
                  if (bitcnt == `BITS_INSTR - 6'h01) begin
                     op_code <= {dsh[6:0], f_io[0]};
                     op_class <= cls_of({dsh[6:0], f_io[0]});
                     abw <= abw_of({dsh[6:0], f_io[0]});
                     dbw <= dbw_of({dsh[6:0], f_io[0]});
                     bitcnt <= 6'h00;
                     ash <= 32'h0;
                     lat_cnt <= 8'h00;
                     op_strobe <= (cls_of({dsh[6:0], f_io[0]}) !=
                                   `CLS_NONE);
                     // fixed opcodes or the extended bit pick 4 bytes
                     op_wide <= (akind_of({dsh[6:0], f_io[0]}) ==
                                 `AK_FIXED4) | wide_address_enable;
                     addr_bits <= ((akind_of({dsh[6:0], f_io[0]}) ==
                                    `AK_FIXED4) | wide_address_enable) ?
                                  `BITS_ADDR4 : `BITS_ADDR3;
                     if (akind_of({dsh[6:0], f_io[0]}) != `AK_NONE) begin
                        state <= ST_ADDR;
                     end else begin
                        case (cls_of({dsh[6:0], f_io[0]}))
                           `CLS_REG_WRITE, `CLS_BANK_WRITE: begin
                              state <= ST_DIN;
                           end
                           `CLS_REG_READ, `CLS_BANK_READ: begin
                              state <= has_lat({dsh[6:0], f_io[0]}) ?
                                       ST_LAT : ST_DOUT;
                           end
                           default: begin
                              state <= ST_IGN;
                           end
                        endcase
                     end
                  end
               end
               ST_ADDR: begin
                  ash <= next_ash;
                  bitcnt <= bitcnt + {3'h0, abw};
                  if (bitcnt + {3'h0, abw} == addr_bits) begin
                     bitcnt <= 6'h00;
                     op_addr_strobe <= 1'b1;
                     if (op_wide) begin
                        op_addr <= next_ash;
                        stream_addr <= next_ash;
                     end else begin
                        // bank register supplies the top byte
                        op_addr <= {bank_address_select & `BANK_SEL_MASK,
                                    next_ash[23:0]};
                        stream_addr <= {bank_address_select &
                                        `BANK_SEL_MASK,
                                        next_ash[23:0]};
                     end
                     case (op_class)
                        `CLS_READ: begin
                           state <= has_lat(op_code) ? ST_LAT : ST_DOUT;
                        end
                        `CLS_PROGRAM: begin
                           state <= ST_DIN;
                        end
                        default: begin
                           state <= ST_IGN;
                        end
                     endcase
                  end
               end
               ST_LAT: begin
                  lat_cnt <= lat_cnt + 8'h01;
                  if (lat_cnt == LAT_CYC[7:0] - 8'h01) begin
                     state <= ST_DOUT;
                  end
               end
               ST_DIN: begin
                  dsh <= next_dsh;
                  bitcnt <= bitcnt + {3'h0, dbw};
                  if (bitcnt + {3'h0, dbw} == {2'h0, `BITS_BYTE}) begin
                     bitcnt <= 6'h00;
                     wr_data <= next_dsh;
                     wr_strobe <= 1'b1;
                     if (op_class == `CLS_BANK_WRITE) begin
                        bank_address_select <= next_dsh;
                        state <= ST_IGN;
                     end
                  end
               end
               ST_DOUT: begin
                  state <= ST_DOUT;
               end
               default: begin
                  state <= ST_IGN;
               end
            endcase
         end else if (sck_fall && state == ST_DOUT) begin
            // single uses io1, dual io1:0, quad io3:0
            io_oe <= (dbw == 3'h4) ? 4'hF :
                     (dbw == 3'h2) ? 4'h3 : 4'h2;
            if (out_left == 4'h0) begin
               out_sh <= next_byte;
               out_left <= `BITS_BYTE - {1'b0, dbw};
               // address runs past bank ends; bank register kept
               if (op_class == `CLS_READ) begin
                  stream_addr <= stream_addr + 32'h1;
               end
            end else begin
               out_sh <= out_sh << dbw;
               out_left <= out_left - {1'b0, dbw};
            end
         end
      end
   end
endmodule

`default_nettype wire

// >>> spfcad_decode_assertions.sv
// assertion checker for the instruction and address decoder
`timescale 1ns/100ps
`default_nettype none
`include "spfcad_defs.vh"
module spfcad_decode_chk (
   // clock and reset
   input wire clk_sys,
   input wire arst_n,
   // watched ports
   input wire cs_n,
   input wire [7:0] op_code,
   input wire [3:0] op_class,
   input wire op_strobe,
   input wire op_wide,
   input wire [31:0] op_addr,
   input wire op_addr_strobe,
   input wire frame_end,
   input wire [7:0] bank_address_select,
   input wire wide_address_enable
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   chk_ext_bit_map: assert property (
      wide_address_enable == bank_address_select[`BANK_EXT_BIT])
      else $error("extended bit differs from bank bit 7");
   chk_bank_after_reset: assert property (
      $rose(arst_n) |-> bank_address_select == `BANK_RESET)
      else $error("bank register not cleared by reset");
   chk_fixed_wide: assert property (
      op_addr_strobe && op_code inside {8'h0C, 8'h13, 8'h3C, 8'h6C,
      8'hBC, 8'hEC, 8'h12, 8'h34, 8'h21, 8'hDC} |-> op_wide)
      else $error("fixed wide opcode took a short address");
   chk_legacy_width: assert property (
      op_addr_strobe && op_code inside {8'h03, 8'h0B, 8'h3B, 8'h6B,
      8'hBB, 8'hEB, 8'h02, 8'h32, 8'h20, 8'hD8}
      |-> op_wide == wide_address_enable)
      else $error("legacy address width ignores extended bit");
   chk_bank_top_byte: assert property (
      op_addr_strobe && !op_wide
      |-> op_addr[31:24] == (bank_address_select & `BANK_SEL_MASK))
      else $error("short address top byte not taken from bank");
   chk_bank_hold: assert property (
      $changed(bank_address_select) |-> op_class == `CLS_BANK_WRITE)
      else $error("bank register changed outside a bank write");
   chk_unknown_quiet: assert property (
      op_strobe |-> op_class != `CLS_NONE)
      else $error("strobe for an unknown instruction");
   chk_strobe_single: assert property (
      op_strobe |=> !op_strobe [*8])
      else $error("instruction strobe repeated too soon");
   chk_frame_close: assert property (
      $rose(cs_n) |-> ##[1:8] frame_end)
      else $error("no frame end after deselect");
   chk_reg_read_cls: assert property (
      op_strobe && op_code inside {8'h05, 8'h07, 8'h35}
      |-> op_class == `CLS_REG_READ)
      else $error("status read not classed as register read");
   cov_wide_addr: cover property (op_addr_strobe && op_wide);
   cov_short_addr: cover property (op_addr_strobe && !op_wide);
   cov_bank_write: cover property (op_strobe && op_class == `CLS_BANK_WRITE);
endmodule
bind spfcad_decode spfcad_decode_chk i_spfcad_decode_chk (.clk_sys,
   .arst_n, .cs_n, .op_code, .op_class, .op_strobe, .op_wide, .op_addr,
   .op_addr_strobe, .frame_end, .bank_address_select, .wide_address_enable);
`default_nettype wire

// >>> spfcad_defs.vh
// constants for the serial flash instruction and address decoder
`ifndef SPFCAD_DEFS_VH
`define SPFCAD_DEFS_VH

// instructions with a fixed 4-byte address
`define OP_QUICK_READ_WIDE 8'h0C
`define OP_NORMAL_READ_WIDE 8'h13
`define OP_READ_DUAL_OUT_WIDE 8'h3C
`define OP_READ_QUAD_OUT_WIDE 8'h6C
`define OP_READ_DUAL_IO_WIDE 8'hBC
`define OP_READ_QUAD_IO_WIDE 8'hEC
`define OP_PAGE_PROGRAM_WIDE 8'h12
`define OP_QUAD_PAGE_PROGRAM_WIDE 8'h34
`define OP_PARAM_4K_WIPE_WIDE 8'h21
`define OP_LARGE_BLOCK_WIPE_WIDE 8'hDC

// legacy instructions, width follows the extended-address bit
`define OP_NORMAL_READ 8'h03
`define OP_QUICK_READ 8'h0B
`define OP_READ_DUAL_OUT 8'h3B
`define OP_READ_QUAD_OUT 8'h6B
`define OP_READ_DUAL_IO 8'hBB
`define OP_READ_QUAD_IO 8'hEB
`define OP_PAGE_PROGRAM 8'h02
`define OP_QUAD_PAGE_PROGRAM 8'h32
`define OP_PARAM_4K_WIPE 8'h20
`define OP_LARGE_BLOCK_WIPE 8'hD8

// identification and register access
`define OP_READ_MAKER_SIGNATURE 8'h90
`define OP_READ_IDENTITY 8'h9F
`define OP_READ_DISCOVERY_PARAMS 8'h5A
`define OP_READ_STATUS_ONE 8'h05
`define OP_READ_STATUS_TWO 8'h07
`define OP_READ_CONFIG_ONE 8'h35
`define OP_WRITE_STATUS_CONFIG 8'h01
`define OP_WRITE_ENABLE_CMD 8'h06
`define OP_WRITE_DISABLE_CMD 8'h04
`define OP_CLEAR_FAIL_FLAGS 8'h30
`define OP_BANK_REG_READ 8'h16
`define OP_BANK_REG_WRITE 8'h17
`define OP_BANK_REG_ACCESS_LEGACY 8'hB9
`define OP_LEARN_PATTERN_READ 8'h41
`define OP_LEARN_PATTERN_NV_PROGRAM 8'h43
`define OP_LEARN_PATTERN_VOL_WRITE 8'h4A

// command classes on op_class
`define CLS_NONE 4'h0
`define CLS_READ 4'h1
`define CLS_PROGRAM 4'h2
`define CLS_ERASE 4'h3
`define CLS_REG_READ 4'h4
`define CLS_REG_WRITE 4'h5
`define CLS_SIMPLE 4'h6
`define CLS_BANK_READ 4'h7
`define CLS_BANK_WRITE 4'h8

// address kinds
`define AK_NONE 2'h0
`define AK_LEGACY 2'h1
`define AK_FIXED4 2'h2

// bank register
`define BANK_RESET 8'h00
`define BANK_EXT_BIT 7
`define BANK_SEL_MASK 8'h7F

// bit counts and idle read byte
`define BITS_INSTR 6'h08
`define BITS_ADDR3 6'h18
`define BITS_ADDR4 6'h20
`define BITS_BYTE 4'h8
`define IDLE_BYTE 8'hFF

`endif

// >>> spfcad_fifo.v
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none

module spfcad_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 4
) (
   // clock and reset
   input wire clk_sys,
   input wire arst_n,
   // filling side
   input wire [WIDTH-1:0] in_data,
   input wire in_valid,
   output wire in_ready,
   // draining side
   output wire [WIDTH-1:0] out_data,
   output wire out_valid,
   input wire out_ready
);
   localparam AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr;
   reg [AW-1:0] rd_ptr;
   reg [AW:0] count;
   wire push;
   wire pop;

   assign in_ready = (count != DEPTH[AW:0]);
   assign out_valid = (count != {(AW+1){1'b0}});
   assign out_data = mem[rd_ptr];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always @(posedge clk_sys) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                      wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                      rd_ptr + 1'b1;
         end
         if (push & !pop) begin
            count <= count + 1'b1;
         end else if (pop & !push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule

`default_nettype wire

// >>> spfcad_host.sv
// host controller model driving the serial pins, mode 0
`timescale 1ns/100ps
`default_nettype none
module spfcad_host (
   // serial pins
   output logic cs_n,
   output logic sck,
   output logic [3:0] io_drv,
   input wire logic [3:0] io_pin
);
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      io_drv = 4'h5;
   end
   task automatic start();
      cs_n = 1'b0;
      #320;
   endtask
   task automatic stop();
      #160 cs_n = 1'b1;
      io_drv = ~io_drv;
      #1200;
   endtask
   // msb first on io0; sck stands low outside frames
   task automatic shift(input logic [31:0] d, input int n,
         output logic [31:0] q);
      q = '0;
      for (int i = n - 1; i >= 0; i--) begin
         io_drv = {~io_drv[3:1], d[i]};
         #160 sck = 1'b1;
         // late sample: device output lags the pin by its sync pipeline
         #159 q = {q[30:0], io_pin[1]};
         #1 sck = 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// >>> tb.sv
// testbench for the instruction and address decoder
`timescale 1ns/100ps
`default_nettype none
`include "spfcad_defs.vh"
module tb;
   logic clk_sys = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] rd_data = 8'h00;
   logic rd_valid = 1'b0;
   wire logic cs_n, sck, rd_ready, op_strobe, op_wide, op_addr_strobe;
   wire logic wr_strobe, frame_end, wide_address_enable;
   wire logic [3:0] io_out, io_oe, op_class, h_io;
   wire logic [7:0] op_code, wr_data, bank_address_select;
   wire logic [31:0] op_addr, stream_addr;
   wire logic [3:0] io_pin = (io_oe & io_out) | (~io_oe & h_io);
   int mismatches = 0;
   int checked = 0;
   int n_op = 0;
   int n_adr = 0;
   logic [31:0] q;
   // {opcode, class}; class F left unchecked, 0 means no strobe
   localparam logic [11:0] DEC_TBL [37] = '{12'h0C1, 12'h131, 12'h3C1,
      12'h6C1, 12'hBC1, 12'hEC1, 12'h122, 12'h342, 12'h213, 12'hDC3,
      12'h031, 12'h0B1, 12'h3B1, 12'h6B1, 12'hBB1, 12'hEB1, 12'h022,
      12'h322, 12'h203, 12'hD83, 12'h90F, 12'h9FF, 12'h5AF, 12'h054,
      12'h074, 12'h354, 12'h015, 12'h066, 12'h046, 12'h306, 12'h167,
      12'h178, 12'hB98, 12'h41F, 12'h43F, 12'h4AF, 12'hA30};
   // single-line address opcodes: fixed wide first, then legacy
   localparam logic [7:0] ADR_OPS [16] = '{8'h0C, 8'h13, 8'h3C, 8'h6C,
      8'h12, 8'h34, 8'h21, 8'hDC, 8'h03, 8'h0B, 8'h3B, 8'h6B, 8'h02,
      8'h32, 8'h20, 8'hD8};
   spfcad_decode #(.LAT_CYC(8), .FIFO_DEPTH(4)) i_spfcad_decode (.clk_sys,
      .arst_n, .cs_n, .sck, .io_in(io_pin), .io_out, .io_oe, .rd_data,
      .rd_valid, .rd_ready, .op_code, .op_class, .op_strobe, .op_wide,
      .op_addr, .op_addr_strobe, .stream_addr, .wr_data, .wr_strobe,
      .frame_end, .bank_address_select, .wide_address_enable);
   spfcad_host i_spfcad_host (.cs_n, .sck, .io_drv(h_io), .io_pin);
   initial begin
      forever #20 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      if (op_strobe === 1'b1) n_op++;
      if (op_addr_strobe === 1'b1) n_adr++;
   end
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp,
         input string what);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what,
            got, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic do_reset();
      arst_n = 1'b0;
      repeat (16) @(posedge clk_sys);
      #1 arst_n = 1'b1;
      repeat (6) @(posedge clk_sys);
      cmp(bank_address_select, `BANK_RESET, "bank after reset");
      cmp(wide_address_enable, 1'b0, "ext bit after reset");
      $display("test reset done");
   endtask
   task automatic bank_wr(input logic [7:0] op, input logic [7:0] v);
      i_spfcad_host.start();
      i_spfcad_host.shift(32'(op), 8, q);
      i_spfcad_host.shift(32'(v), 8, q);
      i_spfcad_host.stop();
      cmp(bank_address_select, v, "bank write");
      cmp(wr_data, v, "write data");
   endtask
   task automatic push(input logic [7:0] v);
      @(posedge clk_sys) #1;
      rd_data = v;
      rd_valid = 1'b1;
      while (rd_ready !== 1'b1) @(posedge clk_sys) #1;
      @(posedge clk_sys) #1;
      rd_valid = 1'b0;
   endtask
   task automatic t_decode();
      int n0;
      for (int k = 0; k < 37; k++) begin
         n0 = n_op;
         i_spfcad_host.start();
         i_spfcad_host.shift(32'(DEC_TBL[k][11:4]), 8, q);
         #400;
         cmp(n_op - n0, DEC_TBL[k][3:0] != 4'h0, "strobe");
         cmp(op_code, DEC_TBL[k][11:4], "opcode");
         if (DEC_TBL[k][3:0] != 4'hF && DEC_TBL[k][3:0] != 4'h0)
            cmp(op_class, DEC_TBL[k][3:0], "class");
         i_spfcad_host.stop();
      end
      $display("test decode done");
   endtask
   task automatic t_addr(input logic [7:0] op, input logic wide,
         input logic [31:0] a);
      int n0;
      n0 = n_adr;
      i_spfcad_host.start();
      i_spfcad_host.shift(32'(op), 8, q);
      i_spfcad_host.shift(wide ? a >> 8 : a, 24, q);
      #400 cmp(n_adr - n0, !wide, "early count");
      if (wide) begin
         i_spfcad_host.shift(a, 8, q);
         #400 cmp(n_adr - n0, 1, "wide count");
      end
      cmp(op_wide, wide, "width");
      // short addresses only run with bank 03 written by t_width
      cmp(op_addr, wide ? a : {8'h03, a[23:0]}, "address");
      i_spfcad_host.stop();
   endtask
   task automatic t_width();
      bank_wr(8'h17, 8'h03);
      for (int k = 0; k < 16; k++)
         t_addr(ADR_OPS[k], k < 8, 32'hA1B2C3D4);
      bank_wr(8'hB9, 8'h83);
      for (int k = 8; k < 16; k++)
         t_addr(ADR_OPS[k], 1'b1, 32'h5A6B7C8D);
      i_spfcad_host.start();
      i_spfcad_host.shift(32'h16, 8, q);
      i_spfcad_host.shift(32'h0, 8, q);
      i_spfcad_host.stop();
      cmp(q[7:0], 8'h83, "bank read");
      $display("test width done");
   endtask
   task automatic t_stream();
      bank_wr(8'h17, 8'h01);
      fork
         for (int k = 1; k < 6; k++) push(8'(k * 8'h11));
      join_none
      repeat (20) @(posedge clk_sys);
      cmp(rd_ready, 1'b0, "fifo full");
      i_spfcad_host.start();
      i_spfcad_host.shift(32'h03, 8, q);
      i_spfcad_host.shift(32'hFFFFFE, 24, q);
      // sixth byte finds the fifo drained
      for (int j = 0; j < 6; j++) begin
         i_spfcad_host.shift(32'h0, 8, q);
         cmp(q[7:0], j < 5 ? 8'((j + 1) * 8'h11) : 8'hFF, "data");
      end
      cmp(io_oe, 4'h2, "single output enable");
      i_spfcad_host.stop();
      cmp(io_oe, 4'h0, "released after frame");
      cmp(op_addr, 32'h01FFFFFE, "start address");
      cmp(stream_addr, 32'h02000005, "stream address");
      cmp(bank_address_select, 8'h01, "bank kept");
      $display("test stream done");
   endtask
   initial begin
      do_reset();
      t_decode();
      t_width();
      t_stream();
      bank_wr(8'h17, 8'h85);
      do_reset();
      print_verdict();
   end
   initial begin
      #3000000;
      mismatches++;
      print_verdict();
   end
endmodule
`default_nettype wire
